// File: del_pkg.sv
// shared constants and types of the dram ecc error log register bank
package del_pkg;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [9:0] DEL_IDX_REFRESH = 10'h0dc;
  localparam logic [9:0] DEL_IDX_SCRATCH = 10'h0de;
  localparam logic [9:0] DEL_IDX_SYNDROME = 10'h0e2;
  localparam logic [9:0] DEL_IDX_ERR_ADDR = 10'h0e4;
  localparam logic [9:0] DEL_IDX_FLAGS = 10'h0f0;
  localparam logic [9:0] DEL_IDX_IRQ_MASK = 10'h0f1;
  localparam int DEL_IDX_LSB = 2;
  localparam int DEL_IDX_MSB = 11;

  // ==========================================================================
  // field layout
  localparam int DEL_RATE_W = 3;
  localparam int DEL_SCRATCH_W = 16;
  localparam int DEL_SYN_W = 8;
  localparam int DEL_EADDR_W = 23;
  localparam int DEL_EADDR_LSB = 9;
  localparam int DEL_CHAN_BIT = 0;
  localparam int DEL_FLAG_W = 2;
  localparam int DEL_FLAG_SBE = 0;
  localparam int DEL_FLAG_MBE = 1;

  // ==========================================================================
  // reset values
  localparam logic [2:0] DEL_RATE_RST = 3'h0;
  localparam logic [15:0] DEL_SCRATCH_RST = 16'h0000;
  localparam logic [1:0] DEL_FLAG_RST = 2'h0;
  localparam logic [31:0] DEL_WORD_ZERO = 32'h0000_0000;

  // ==========================================================================
  // refresh rate codes, all others reserved
  localparam logic [2:0] DEL_RFSH_OFF = 3'h0;
  localparam logic [2:0] DEL_RFSH_FAST = 3'h1;
  localparam logic [2:0] DEL_RFSH_SLOW = 3'h2;

  // ==========================================================================
  // timing, intervals rounded down to whole cycles
  localparam int DEL_CLK_MHZ = 200;
  localparam int DEL_RFSH_FAST_NS = 1950;
  localparam int DEL_RFSH_SLOW_NS = 3900;
  localparam int DEL_RFSH_FAST_CYC = DEL_RFSH_FAST_NS * DEL_CLK_MHZ / 1000;
  localparam int DEL_RFSH_SLOW_CYC = DEL_RFSH_SLOW_NS * DEL_CLK_MHZ / 1000;

  // ==========================================================================
  // bus encodings
  localparam logic [1:0] DEL_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DEL_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] DEL_HSIZE_WORD = 3'h2;
  localparam logic DEL_HRESP_OKAY = 1'b0;

  // ==========================================================================
  // types
  typedef struct packed {
    logic valid;
    logic multi;
    logic [DEL_SYN_W-1:0] syndrome;
    logic [DEL_EADDR_W-1:0] addr;
    logic channel;
  } del_ecc_evt_t;

  typedef struct packed {
    logic [DEL_SYN_W-1:0] syndrome;
    logic [DEL_EADDR_W-1:0] addr;
    logic channel;
    logic rec_multi;
    logic [DEL_FLAG_W-1:0] flags;
  } del_capture_t;

  typedef enum logic [1:0] {
    DEL_ST_IDLE = 2'b00,
    DEL_ST_WR = 2'b01,
    DEL_ST_RD1 = 2'b11,
    DEL_ST_RD2 = 2'b10
  } del_bus_st_t;

endpackage

// File: del_refresh_timer.sv
// refresh request timer for memory channel pair 0
`timescale 1ns/10ps
`default_nettype none
module del_refresh_timer
  import del_pkg::*;
#(
  parameter int CNT_W = 10,
  parameter logic [CNT_W-1:0] FAST_CYC = CNT_W'(DEL_RFSH_FAST_CYC),
  parameter logic [CNT_W-1:0] SLOW_CYC = CNT_W'(DEL_RFSH_SLOW_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // rate select and request
  input wire logic [DEL_RATE_W-1:0] rate,
  output logic refresh_req
);

  typedef struct packed {
    logic [DEL_RATE_W-1:0] rate;
    logic [CNT_W-1:0] cnt;
    logic req;
  } del_tmr_st_t;

  del_tmr_st_t st;
  del_tmr_st_t next_st;
  logic [CNT_W-1:0] period;

  // ==========================================================================
  // interval selection and count
  always_comb begin
    next_st = st;
    next_st.req = 1'b0;
    next_st.rate = rate;
    unique case (rate)
      DEL_RFSH_FAST: period = FAST_CYC;
      DEL_RFSH_SLOW: period = SLOW_CYC;
      default: period = '0; // off or reserved: no refresh
    endcase
    if ((period == '0) || (rate != st.rate)) begin
      next_st.cnt = '0;
    end else if (st.cnt == period - CNT_W'(1)) begin
      next_st.cnt = '0;
      next_st.req = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st <= '{rate: DEL_RATE_RST, cnt: '0, req: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign refresh_req = st.req;

endmodule
`default_nettype wire

// File: del_err_capture.sv
// ecc error flags and locked syndrome, address and channel record
`timescale 1ns/10ps
`default_nettype none
module del_err_capture
  import del_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // error report from the datapath
  input wire del_ecc_evt_t evt,
  // write-one-to-clear of the flags
  input wire logic [DEL_FLAG_W-1:0] flag_clr,
  // captured record
  output del_capture_t cap
);

  del_capture_t st;
  del_capture_t next_st;
  logic [DEL_FLAG_W-1:0] flag_set;
  logic unlocked;

  // ==========================================================================
  // capture and lock
  always_comb begin
    next_st = st;
    flag_set = '0;
    flag_set[DEL_FLAG_SBE] = evt.valid & ~evt.multi;
    flag_set[DEL_FLAG_MBE] = evt.valid & evt.multi;
    // record opens when the flags are clear once this cycle's clear acts
    unlocked = ((st.flags & ~flag_clr) == '0);
    if (evt.valid && (unlocked || (evt.multi && !st.rec_multi))) begin
      next_st.syndrome = evt.syndrome;
      next_st.addr = evt.addr;
      next_st.channel = evt.channel;
      next_st.rec_multi = evt.multi;
    end
    // a new event wins over a clear in the same cycle
    next_st.flags = (st.flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st <= '{syndrome: '0, addr: '0, channel: 1'b0, rec_multi: 1'b0, flags: DEL_FLAG_RST};
    end else begin
      st <= next_st;
    end
  end

  assign cap = st;

endmodule
`default_nettype wire

// File: del_ecc_log_regs.sv
// ahb-lite register bank: refresh rate, scratchpad, ecc error log, interrupt
// Function
// - the three-bit pair 0 refresh field picks off (000), 1.95 us (001) or 3.9 us (010), other codes reserved.
// - with the off code no refresh is issued to pair 0.
// - a sixteen-bit scratchpad is read/write and affects nothing else.
// - on an ecc error the eight-bit syndrome field is loaded.
// - the syndrome stays frozen until software clears the error flag.
// - a multiple-bit error replaces a captured single-bit record before the flag is cleared.
// - any other later error before the clear is not recorded.
// - the error address register holds address bits 33:11 in bits 31:9.
// - the address records the first error after the clear, a multiple-bit one replacing a single-bit one.
// - once the flags are set the address holds against new errors until cleared.
// - bit 0 reports channel b (1) or a (0) and stays locked while the flags are set; here a multiple-bit error still replaces it over a single-bit record.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module del_ecc_log_regs
  import del_pkg::*;
#(
  parameter int RFSH_CNT_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // memory datapath
  input wire del_ecc_evt_t ecc_evt,
  output logic refresh_req_pair0,
  // interrupt
  output logic irq
);

  typedef struct packed {
    del_bus_st_t bus_st;
    logic [9:0] idx;
    logic hit;
    logic wr_ok;
    logic [31:0] rdata;
    logic [DEL_RATE_W-1:0] refresh_rate_pair0;
    logic [DEL_SCRATCH_W-1:0] scratch_storage;
    logic [DEL_FLAG_W-1:0] irq_mask;
  } del_regs_st_t;

  del_regs_st_t st;
  del_regs_st_t next_st;
  del_capture_t cap;
  logic accept;
  logic wr_now;
  logic [DEL_FLAG_W-1:0] flag_clr;
  logic [31:0] rd_word;

  // ==========================================================================
  // read mux
  always_comb begin
    rd_word = DEL_WORD_ZERO;
    if (st.hit) begin
      unique case (st.idx)
        DEL_IDX_REFRESH: rd_word[DEL_RATE_W-1:0] = st.refresh_rate_pair0;
        DEL_IDX_SCRATCH: rd_word[DEL_SCRATCH_W-1:0] = st.scratch_storage;
        DEL_IDX_SYNDROME: rd_word[DEL_SYN_W-1:0] = cap.syndrome;
        DEL_IDX_ERR_ADDR: begin
          rd_word[DEL_EADDR_LSB +: DEL_EADDR_W] = cap.addr;
          rd_word[DEL_CHAN_BIT] = cap.channel;
        end
        DEL_IDX_FLAGS: rd_word[DEL_FLAG_W-1:0] = cap.flags;
        DEL_IDX_IRQ_MASK: rd_word[DEL_FLAG_W-1:0] = st.irq_mask;
        default: rd_word = DEL_WORD_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // bus sequencing and register writes
  assign accept = hsel && hready && ((htrans == DEL_HTRANS_NONSEQ) || (htrans == DEL_HTRANS_SEQ));
  assign wr_now = (st.bus_st == DEL_ST_WR) && st.wr_ok && st.hit;

  always_comb begin
    next_st = st;
    flag_clr = '0;
    if (wr_now) begin
      unique case (st.idx)
        DEL_IDX_REFRESH: next_st.refresh_rate_pair0 = hwdata[DEL_RATE_W-1:0];
        DEL_IDX_SCRATCH: next_st.scratch_storage = hwdata[DEL_SCRATCH_W-1:0];
        DEL_IDX_FLAGS: flag_clr = hwdata[DEL_FLAG_W-1:0];
        DEL_IDX_IRQ_MASK: next_st.irq_mask = hwdata[DEL_FLAG_W-1:0];
        default: flag_clr = '0; // read-only or unmapped: write ignored
      endcase
    end
    unique case (st.bus_st)
      DEL_ST_RD1: begin
        next_st.rdata = rd_word;
        next_st.bus_st = DEL_ST_RD2;
      end
      DEL_ST_IDLE, DEL_ST_WR, DEL_ST_RD2: begin
        if (accept) begin
          next_st.idx = haddr[DEL_IDX_MSB:DEL_IDX_LSB];
          next_st.hit = (haddr[31:DEL_IDX_MSB+1] == '0) && (haddr[DEL_IDX_LSB-1:0] == '0);
          next_st.wr_ok = (hsize == DEL_HSIZE_WORD);
          next_st.bus_st = hwrite ? DEL_ST_WR : DEL_ST_RD1;
        end else begin
          next_st.bus_st = DEL_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st <= '{bus_st: DEL_ST_IDLE, idx: '0, hit: 1'b0, wr_ok: 1'b0, rdata: DEL_WORD_ZERO,
              refresh_rate_pair0: DEL_RATE_RST, scratch_storage: DEL_SCRATCH_RST,
              irq_mask: DEL_FLAG_RST};
    end else begin
      st <= next_st;
    end
  end

  // one wait state on reads so the data come from a register
  assign hreadyout = (st.bus_st != DEL_ST_RD1);
  assign hrdata = st.rdata;
  assign hresp = DEL_HRESP_OKAY;
  assign irq = |(cap.flags & st.irq_mask);

  // ==========================================================================
  // submodules
  del_err_capture u_capture (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .evt(ecc_evt),
    .flag_clr(flag_clr),
    .cap(cap)
  );

  del_refresh_timer #(
    .CNT_W(RFSH_CNT_W)
  ) u_refresh (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .rate(st.refresh_rate_pair0),
    .refresh_req(refresh_req_pair0)
  );

endmodule
`default_nettype wire

// File: del_ecc_log_regs_assertions.sv
// concurrent checks on the ports of the ecc error log register bank
`timescale 1ns/10ps
`default_nettype none
module del_ecc_log_regs_assertions
  import del_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // datapath and interrupt
  input wire del_ecc_evt_t ecc_evt,
  input wire logic refresh_req_pair0,
  input wire logic irq
);
  localparam int RF_GAP = DEL_RFSH_FAST_CYC - 1;
  logic take;
  logic wr_dp;
  logic rd_dp;
  logic [9:0] gap;
  assign take = hsel & hready & htrans[1];
  // ==========================================================================
  // data phase markers and cycles since the last refresh pulse
  always_ff @(posedge core_clk) begin
    wr_dp <= reset_n & take & hwrite;
    rd_dp <= reset_n & take & ~hwrite;
    gap <= (!reset_n || refresh_req_pair0) ? 10'h000 : gap + {9'h000, gap != 10'h3ff};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // ==========================================================================
  // properties
  a_resp_okay: assert property (hresp == DEL_HRESP_OKAY) else $error("bus response not okay");
  a_read_wait: assert property (take && !hwrite |=> s_rd_wait) else $error("read wait state wrong");
  a_write_ready: assert property (wr_dp |-> hreadyout) else $error("write data phase stalled");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_dp)) else $error("read data moved");
  a_refresh_pulse: assert property (refresh_req_pair0 |=> !refresh_req_pair0) else $error("refresh too long");
  a_refresh_gap: assert property (refresh_req_pair0 |-> gap >= RF_GAP) else $error("refresh too soon");
  a_irq_cause: assert property ($rose(irq) |-> $past(ecc_evt.valid) || $past(wr_dp)) else $error("irq no cause");
  a_irq_clear: assert property ($fell(irq) |-> $past(wr_dp)) else $error("irq fell without write");
endmodule
bind del_ecc_log_regs del_ecc_log_regs_assertions u_chk (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .ecc_evt(ecc_evt), .refresh_req_pair0(refresh_req_pair0), .irq(irq));
`default_nettype wire

// File: del_dp_model.sv
// memory datapath model: reports ecc errors and counts refresh requests
`timescale 1ns/10ps
`default_nettype none
module del_dp_model
  import del_pkg::*;
(
  // clock
  input wire logic core_clk,
  // refresh request from the bank
  input wire logic refresh_req,
  // error report and refresh count
  output del_ecc_evt_t ecc_evt,
  output int rf_n
);
  initial begin
    ecc_evt = '0;
    rf_n = 0;
  end
  always @(posedge core_clk) begin
    if (refresh_req === 1'b1) begin
      rf_n <= rf_n + 1;
    end
  end
  // one-cycle report, then idle fields flipped so stale values never match
  task automatic report(input logic m, input logic [7:0] s, input logic [22:0] a, input logic c);
    @(posedge core_clk);
    ecc_evt <= '{valid: 1'b1, multi: m, syndrome: s, addr: a, channel: c};
    @(posedge core_clk);
    ecc_evt <= '{valid: 1'b0, multi: ~m, syndrome: ~s, addr: ~a, channel: ~c};
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: del_ecc_log_regs_test.sv
// self-checking bench of the ecc error log register bank
`timescale 1ns/10ps
`default_nettype none
module del_ecc_log_regs_test
  import del_pkg::*;
;
  logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, rfsh, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  del_ecc_evt_t ecc_evt;
  int rf_n, bad_count, total_checks, n0;
  logic [9:0] regs [6] = '{DEL_IDX_REFRESH, DEL_IDX_SCRATCH, DEL_IDX_SYNDROME, DEL_IDX_ERR_ADDR,
    DEL_IDX_FLAGS, DEL_IDX_IRQ_MASK};
  int rf_exp [4] = '{0, 4, 2, 0};
`define CHK(w, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", w, e, g); end end
  del_ecc_log_regs u_del_ecc_log_regs (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ecc_evt(ecc_evt), .refresh_req_pair0(rfsh),
    .irq(irq));
  del_dp_model u_del_dp_model (.core_clk(core_clk), .refresh_req(rfsh), .ecc_evt(ecc_evt), .rf_n(rf_n));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // waits for hready high at a rising edge and takes the read data at that edge
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) begin
        rd = hrdata;
        break;
      end
    end
    if (n == 20) begin
      bad_count++;
      $display("mismatch hready expected 1 seen 0");
      test_done();
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= DEL_HTRANS_NONSEQ;
    haddr <= {20'h00000, idx, 2'b00};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    `CHK($sformatf("reg %h", idx), e, rd)
  endtask
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = DEL_HSIZE_WORD;
    hwdata = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (regs[i]) rchk(regs[i], DEL_WORD_ZERO);
    bus(1'b1, DEL_IDX_SCRATCH, 32'hffff_a5c3);
    rchk(DEL_IDX_SCRATCH, 32'h0000_a5c3);
    // a write of less than a word is accepted but leaves the register alone
    hsize <= 3'h0;
    bus(1'b1, DEL_IDX_SCRATCH, 32'h0000_1234);
    hsize <= DEL_HSIZE_WORD;
    rchk(DEL_IDX_SCRATCH, 32'h0000_a5c3);
    bus(1'b1, DEL_IDX_SYNDROME, 32'hffff_ffff);
    rchk(DEL_IDX_SYNDROME, 32'h0);
    bus(1'b1, 10'h0dd, 32'hffff_ffff);
    rchk(10'h0dd, 32'h0);
    bus(1'b1, DEL_IDX_IRQ_MASK, 32'h3);
    u_del_dp_model.report(1'b0, 8'h11, 23'h12_3456, 1'b1);
    `CHK("irq", 1'b1, irq)
    rchk(DEL_IDX_SYNDROME, 32'h11);
    rchk(DEL_IDX_ERR_ADDR, {23'h12_3456, 8'h00, 1'b1});
    u_del_dp_model.report(1'b0, 8'h22, 23'h05_5555, 1'b0);
    rchk(DEL_IDX_SYNDROME, 32'h11);
    rchk(DEL_IDX_ERR_ADDR, {23'h12_3456, 8'h00, 1'b1});
    u_del_dp_model.report(1'b1, 8'h33, 23'h7a_bcde, 1'b0);
    rchk(DEL_IDX_SYNDROME, 32'h33);
    rchk(DEL_IDX_ERR_ADDR, {23'h7a_bcde, 8'h00, 1'b0});
    u_del_dp_model.report(1'b1, 8'h44, 23'h00_0001, 1'b1);
    rchk(DEL_IDX_SYNDROME, 32'h33);
    rchk(DEL_IDX_FLAGS, 32'h3);
    bus(1'b1, DEL_IDX_FLAGS, 32'h3);
    @(negedge core_clk);
    `CHK("irq", 1'b0, irq)
    u_del_dp_model.report(1'b1, 8'h55, 23'h00_0002, 1'b1);
    u_del_dp_model.report(1'b0, 8'h66, 23'h00_0003, 1'b0);
    rchk(DEL_IDX_SYNDROME, 32'h55);
    rchk(DEL_IDX_ERR_ADDR, {23'h00_0002, 8'h00, 1'b1});
    bus(1'b1, DEL_IDX_FLAGS, 32'h3);
    bus(1'b1, DEL_IDX_IRQ_MASK, 32'h0);
    u_del_dp_model.report(1'b0, 8'h77, 23'h00_0004, 1'b0);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, DEL_IDX_IRQ_MASK, 32'h1);
    @(negedge core_clk);
    `CHK("irq", 1'b1, irq)
    rchk(DEL_IDX_SYNDROME, 32'h77);
    bus(1'b1, DEL_IDX_FLAGS, 32'h3);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, DEL_IDX_REFRESH, {29'h0, 3'(i)});
      n0 = rf_n;
      repeat (1600) @(posedge core_clk);
      `CHK("refresh pulses", rf_exp[i], rf_n - n0)
    end
    bus(1'b1, DEL_IDX_REFRESH, 32'hffff_fffb);
    rchk(DEL_IDX_REFRESH, 32'h3);
    test_done();
  end
endmodule
`default_nettype wire
